// File: hdl/cpu_config_sfr_bank.sv
// Special-function and configuration register bank of the processor core
`timescale 1ns/1ps
`include "cpu_config_map.svh"

////////////////////////////////////////////////////////////////////////////
module cpu_config_sfr_bank
    import cpu_config_pkg::*;
(
    // Clock and reset
    input  wire         clk_in,
    input  wire         rst_n_in,
    // SFR bus from the core
    input  sfr_req_t    sfr_req_in,
    output logic [7:0]  sfr_rdata_out,
    output logic        sfr_rvalid_out,
    // External RAM bus from the core
    input  xram_req_t   xram_req_in,
    output logic [7:0]  xram_rdata_out,
    output logic        xram_rvalid_out,
    // Host load request writing the core reset bit
    input  wire         host_load_wr_in,
    input  wire         host_load_bit_in,
    // Endpoint and waveform engine status
    input  wire [2:0]   ep_busy_in,
    input  wire [1:0]   interface_mode_in,
    input  wire         bus_16_in,
    input  wire         xfer_done_in,
    input  wire         sgl_rvalid_in,
    input  wire [15:0]  sgl_rdata_in,
    // Waveform engine commands
    output logic        fifo_go_out,
    output logic [2:0]  fifo_sel_out,
    output logic        sgl_go_out,
    output logic        sgl_go_rd_out,
    output logic [7:0]  sgl_high_out,
    output logic [7:0]  sgl_low_out,
    // Port C accesses
    input  wire         portc_rd_in,
    input  wire         portc_wr_in,
    // Pins and core controls
    output logic [7:0]  port_e_oe_out,
    output logic [1:0]  cpu_speed_out,
    output logic        core_reset_out,
    output logic        clk_pin_out,
    output logic        clk_pin_oe_out,
    output logic        rd_strobe_n_out,
    output logic        wr_strobe_n_out
);

    bank_regs_t r_r;
    bank_regs_t r_nxt;
    logic [2:0] alias_wr;
    logic [2:0] alias_rd;
    logic       wave_hit;
    logic       wave_wr;
    logic [7:0] wave_q;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // External RAM alias decode
    function automatic logic [2:0] alias_of(input logic [15:0] a);
        case (a)
            `XR_CPU_CTRL:      alias_of = `AL_CPU;
            `XR_EP0_STAT:      alias_of = `AL_EP0;
            `XR_EP1_OUT_STAT:  alias_of = `AL_EP1O;
            `XR_EP1_IN_STAT:   alias_of = `AL_EP1I;
            `XR_SGL_HIGH:      alias_of = `AL_SGLH;
            `XR_SGL_LOW_TRIG:  alias_of = `AL_SGLLX;
            `XR_SGL_LOW_QUIET: alias_of = `AL_SGLLN;
            default:           alias_of = `AL_NONE;
        endcase
    endfunction : alias_of

    // Processor control byte as firmware reads it
    function automatic logic [7:0] cpu_byte(input cpu_ctrl_t c,
                                            input logic rst);
        cpu_byte = 8'h00;
        cpu_byte[`CPU_STROBE_BIT] = c.strobe_en;
        cpu_byte[`CPU_SPEED_HI:`CPU_SPEED_LO] = c.speed;
        cpu_byte[`CPU_INVERT_BIT] = c.invert;
        cpu_byte[`CPU_DRIVE_BIT] = c.drive;
        cpu_byte[`CPU_CORE_RST_BIT] = rst;
    endfunction : cpu_byte

    // Endpoint busy byte, upper bits zero
    function automatic logic [7:0] busy_byte(input logic [2:0] b);
        busy_byte = {5'h00, b};
    endfunction : busy_byte

    // Descriptor window is live only in the internal master mode
    assign wave_hit = (interface_mode_in == `MODE_WAVE_MASTER) &&
                      (xram_req_in.addr >= `XR_WAVE_FIRST) &&
                      (xram_req_in.addr <= `XR_WAVE_LAST);
    assign wave_wr  = wave_hit && xram_req_in.wr;
    assign alias_wr = xram_req_in.wr ? alias_of(xram_req_in.addr) : `AL_NONE;
    assign alias_rd = alias_of(xram_req_in.addr);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    always_comb begin
        r_nxt = r_r;
        r_nxt.fifo_go = 1'b0;
        r_nxt.sgl_go = 1'b0;
        r_nxt.sgl_go_rd = 1'b0;
        r_nxt.sfr_valid = 1'b0;
        r_nxt.ep_busy = ep_busy_in;

        // SFR writes
        if (sfr_req_in.wr) begin
            case (sfr_req_in.addr)
                `SFR_PORT_E_OE: r_nxt.port_e_oe = sfr_req_in.wdata;
                `SFR_XFER_TRIGGER: begin
                    r_nxt.trig_sel = sfr_req_in.wdata[`TRIG_SEL_HI:0];
                    r_nxt.trig_done = 1'b0;
                    r_nxt.fifo_go = 1'b1;
                end
                `SFR_SGL_HIGH: r_nxt.sgl_high = sfr_req_in.wdata;
                `SFR_SGL_LOW_TRIG: begin
                    r_nxt.sgl_low = sfr_req_in.wdata;
                    r_nxt.sgl_go = 1'b1;
                    r_nxt.trig_done = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // SFR read, triggering read on the low byte with trigger
        if (sfr_req_in.rd) begin
            r_nxt.sfr_valid = 1'b1;
            case (sfr_req_in.addr)
                `SFR_PORT_E_OE:     r_nxt.sfr_rdata = r_r.port_e_oe;
                `SFR_EP01_BUSY:     r_nxt.sfr_rdata = busy_byte(r_r.ep_busy);
                `SFR_XFER_TRIGGER:  r_nxt.sfr_rdata =
                    {r_r.trig_done, 4'h0, r_r.trig_sel};
                `SFR_SGL_HIGH:      r_nxt.sfr_rdata = r_r.sgl_high;
                `SFR_SGL_LOW_TRIG:  r_nxt.sfr_rdata = r_r.sgl_low;
                `SFR_SGL_LOW_QUIET: r_nxt.sfr_rdata = r_r.sgl_low;
                default:            r_nxt.sfr_rdata = 8'h00;
            endcase
            if (sfr_req_in.addr == `SFR_SGL_LOW_TRIG && !sfr_req_in.wr) begin
                r_nxt.sgl_go = 1'b1;
                r_nxt.sgl_go_rd = 1'b1;
                r_nxt.trig_done = 1'b0;
            end
        end

        // External RAM writes to aliases and processor control
        case (alias_wr)
            `AL_CPU: begin
                r_nxt.cpu.strobe_en = xram_req_in.wdata[`CPU_STROBE_BIT];
                r_nxt.cpu.invert = xram_req_in.wdata[`CPU_INVERT_BIT];
                r_nxt.cpu.drive = xram_req_in.wdata[`CPU_DRIVE_BIT];
                if (xram_req_in.wdata[`CPU_SPEED_HI:`CPU_SPEED_LO]
                    != `SPEED_RSVD) begin
                    r_nxt.cpu.speed =
                        xram_req_in.wdata[`CPU_SPEED_HI:`CPU_SPEED_LO];
                end
            end
            `AL_SGLH: r_nxt.sgl_high = xram_req_in.wdata;
            `AL_SGLLX: begin
                r_nxt.sgl_low = xram_req_in.wdata;
                r_nxt.sgl_go = 1'b1;
                r_nxt.trig_done = 1'b0;
            end
            default: begin
            end
        endcase

        // External RAM read, first stage
        r_nxt.hold_valid = xram_req_in.rd;
        r_nxt.hold_wave = wave_hit;
        case (alias_rd)
            `AL_CPU:   r_nxt.hold = cpu_byte(r_r.cpu, r_r.core_rst);
            `AL_EP0:   r_nxt.hold =
                8'(r_r.ep_busy[`EP0_BUSY_BIT]) << `EP_STAT_BUSY_BIT;
            `AL_EP1O:  r_nxt.hold =
                8'(r_r.ep_busy[`EP1_OUT_BUSY_BIT]) << `EP_STAT_BUSY_BIT;
            `AL_EP1I:  r_nxt.hold =
                8'(r_r.ep_busy[`EP1_IN_BUSY_BIT]) << `EP_STAT_BUSY_BIT;
            `AL_SGLH:  r_nxt.hold = r_r.sgl_high;
            `AL_SGLLX: r_nxt.hold = r_r.sgl_low;
            `AL_SGLLN: r_nxt.hold = r_r.sgl_low;
            default:   r_nxt.hold = 8'h00;
        endcase
        if (xram_req_in.rd && !xram_req_in.wr && alias_rd == `AL_SGLLX) begin
            r_nxt.sgl_go = 1'b1;
            r_nxt.sgl_go_rd = 1'b1;
            r_nxt.trig_done = 1'b0;
        end

        // External RAM read, second stage picks memory or register
        r_nxt.xram_valid = r_r.hold_valid;
        r_nxt.xram_rdata = r_r.hold_wave ? wave_q : r_r.hold;

        // Host load request owns the core reset bit
        if (host_load_wr_in) begin
            r_nxt.core_rst = host_load_bit_in;
        end

        // Engine results win over a same-cycle firmware access
        if (sgl_rvalid_in) begin
            r_nxt.sgl_high = bus_16_in ? sgl_rdata_in[15:8] : 8'h00;
            r_nxt.sgl_low = sgl_rdata_in[7:0];
        end
        if (xfer_done_in) begin
            r_nxt.trig_done = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_r <= '0;
            r_r.port_e_oe <= `PORT_E_OE_RESET;
            r_r.ep_busy <= `EP_BUSY_RESET;
            r_r.trig_done <= `TRIG_DONE_RESET;
            r_r.cpu.speed <= `SPEED_RESET;
            r_r.cpu.drive <= `DRIVE_RESET;
            r_r.core_rst <= `CORE_RST_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    // Descriptor memory, four tables in one 128-byte window
    wave_desc_mem u_wave (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .addr_in   (xram_req_in.addr[`WAVE_AW-1:0]),
        .wr_in     (wave_wr),
        .wdata_in  (xram_req_in.wdata),
        .rdata_out (wave_q)
    );

    // Clock output pin and port C strobes
    clk_out_strobes u_strobes (
        .clk_in          (clk_in),
        .rst_n_in        (rst_n_in),
        .ctrl_in         (r_r.cpu),
        .portc_rd_in     (portc_rd_in),
        .portc_wr_in     (portc_wr_in),
        .clk_pin_out     (clk_pin_out),
        .clk_pin_oe_out  (clk_pin_oe_out),
        .rd_strobe_n_out (rd_strobe_n_out),
        .wr_strobe_n_out (wr_strobe_n_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from registers

    assign sfr_rdata_out   = r_r.sfr_rdata;
    assign sfr_rvalid_out  = r_r.sfr_valid;
    assign xram_rdata_out  = r_r.xram_rdata;
    assign xram_rvalid_out = r_r.xram_valid;
    assign fifo_go_out     = r_r.fifo_go;
    assign fifo_sel_out    = r_r.trig_sel;
    assign sgl_go_out      = r_r.sgl_go;
    assign sgl_go_rd_out   = r_r.sgl_go_rd;
    assign sgl_high_out    = r_r.sgl_high;
    assign sgl_low_out     = r_r.sgl_low;
    assign port_e_oe_out   = r_r.port_e_oe;
    assign cpu_speed_out   = r_r.cpu.speed;
    assign core_reset_out  = r_r.core_rst;

endmodule : cpu_config_sfr_bank

// File: include/cpu_config_map.svh
// Register map constants of the SFR bank
`ifndef CPU_CONFIG_MAP_SVH
`define CPU_CONFIG_MAP_SVH

// SFR space offsets
`define SFR_PORT_E_OE        8'hb6
`define SFR_EP01_BUSY        8'hba
`define SFR_XFER_TRIGGER     8'hbb
`define SFR_SGL_HIGH         8'hbd
`define SFR_SGL_LOW_TRIG     8'hbe
`define SFR_SGL_LOW_QUIET    8'hbf

// External RAM space addresses
`define XR_CPU_CTRL          16'he600
`define XR_EP0_STAT          16'he6a0
`define XR_EP1_OUT_STAT      16'he6a1
`define XR_EP1_IN_STAT       16'he6a2
`define XR_SGL_HIGH          16'he6f0
`define XR_SGL_LOW_TRIG      16'he6f1
`define XR_SGL_LOW_QUIET     16'he6f2
`define XR_WAVE_FIRST        16'he400
`define XR_WAVE_LAST         16'he47f
`define WAVE_AW              7

// Alias codes returned by the external RAM decoder
`define AL_NONE              3'h0
`define AL_CPU               3'h1
`define AL_EP0               3'h2
`define AL_EP1O              3'h3
`define AL_EP1I              3'h4
`define AL_SGLH              3'h5
`define AL_SGLLX             3'h6
`define AL_SGLLN             3'h7

// Endpoint busy positions
`define EP0_BUSY_BIT         0
`define EP1_OUT_BUSY_BIT     1
`define EP1_IN_BUSY_BIT      2
`define EP_STAT_BUSY_BIT     1

// Processor control field positions
`define CPU_STROBE_BIT       5
`define CPU_SPEED_HI         4
`define CPU_SPEED_LO         3
`define CPU_INVERT_BIT       2
`define CPU_DRIVE_BIT        1
`define CPU_CORE_RST_BIT     0

// Trigger register field positions
`define TRIG_DONE_BIT        7
`define TRIG_SEL_HI          2

// Reset values
`define PORT_E_OE_RESET      8'h00
`define EP_BUSY_RESET        3'h0
`define TRIG_DONE_RESET      1'b1
`define SPEED_RESET          2'b00
`define DRIVE_RESET          1'b1
`define CORE_RST_RESET       1'b0

// Codes
`define MODE_WAVE_MASTER     2'b10
`define SPEED_12             2'b00
`define SPEED_24             2'b01
`define SPEED_48             2'b10
`define SPEED_RSVD           2'b11

// Clock output half periods in clk_in cycles, strobe length in clock output rises
`define HALF_12              4'h4
`define HALF_24              4'h2
`define HALF_48              4'h1
`define STROBE_EDGES         2'h2

`endif

// File: include/cpu_config_pkg.sv
// Types shared by the SFR bank modules
package cpu_config_pkg;

    // One bus request from the processor core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sfr_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } xram_req_t;

    // Writable processor control fields
    typedef struct packed {
        logic       strobe_en;
        logic [1:0] speed;
        logic       invert;
        logic       drive;
    } cpu_ctrl_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WR_WAIT = 2'b01,
        ST_WR_ACT = 2'b10,
        ST_RD_ACT = 2'b11
    } strobe_state_t;

    typedef struct packed {
        logic [3:0]    div_cnt;
        logic          phase;
        logic          pin;
        logic          pin_oe;
        strobe_state_t st;
        logic [1:0]    edges;
        logic          rd_n;
        logic          wr_n;
    } strobe_regs_t;

    typedef struct packed {
        logic [127:0][7:0] mem;
        logic [7:0]        q;
    } wave_regs_t;

    typedef struct packed {
        logic [7:0] port_e_oe;
        logic [2:0] ep_busy;
        logic       trig_done;
        logic [2:0] trig_sel;
        logic [7:0] sgl_high;
        logic [7:0] sgl_low;
        cpu_ctrl_t  cpu;
        logic       core_rst;
        logic       fifo_go;
        logic       sgl_go;
        logic       sgl_go_rd;
        logic [7:0] sfr_rdata;
        logic       sfr_valid;
        logic [7:0] hold;
        logic       hold_wave;
        logic       hold_valid;
        logic [7:0] xram_rdata;
        logic       xram_valid;
    } bank_regs_t;

endpackage : cpu_config_pkg

// File: hdl/wave_desc_mem.sv
// Byte-wide waveform descriptor store with registered read data
`timescale 1ns/1ps
`include "cpu_config_map.svh"

module wave_desc_mem
    import cpu_config_pkg::*;
(
    // Clock and reset
    input  wire                 clk_in,
    input  wire                 rst_n_in,
    // Access
    input  wire [`WAVE_AW-1:0]  addr_in,
    input  wire                 wr_in,
    input  wire [7:0]           wdata_in,
    output logic [7:0]          rdata_out
);

    wave_regs_t r_r;
    wave_regs_t r_nxt;

    // Write a byte, read the addressed byte every cycle
    always_comb begin
        r_nxt = r_r;
        if (wr_in) begin
            r_nxt.mem[addr_in] = wdata_in;
        end
        r_nxt.q = r_r.mem[addr_in];
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign rdata_out = r_r.q;

endmodule : wave_desc_mem

// File: hdl/clk_out_strobes.sv
// Clock output divider and port C read/write strobe timing
`timescale 1ns/1ps
`include "cpu_config_map.svh"

module clk_out_strobes
    import cpu_config_pkg::*;
(
    // Clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // Control fields
    input  cpu_ctrl_t  ctrl_in,
    // Port C accesses, one-cycle pulses
    input  wire        portc_rd_in,
    input  wire        portc_wr_in,
    // Pins
    output logic       clk_pin_out,
    output logic       clk_pin_oe_out,
    output logic       rd_strobe_n_out,
    output logic       wr_strobe_n_out
);

    strobe_regs_t r_r;
    strobe_regs_t r_nxt;
    logic [3:0]   half;
    logic         rise;

    // Half period for the selected speed
    function automatic logic [3:0] half_of(input logic [1:0] spd);
        case (spd)
            `SPEED_24: half_of = `HALF_24;
            `SPEED_48: half_of = `HALF_48;
            default:   half_of = `HALF_12;
        endcase
    endfunction : half_of

    always_comb begin
        r_nxt = r_r;
        half = half_of(ctrl_in.speed);
        rise = 1'b0;
        // Divider for the clock output
        if (r_r.div_cnt >= half - 4'h1) begin
            r_nxt.div_cnt = 4'h0;
            r_nxt.phase = ~r_r.phase;
            rise = ~r_r.phase;
        end else begin
            r_nxt.div_cnt = r_r.div_cnt + 4'h1;
        end
        r_nxt.pin = r_nxt.phase ^ ctrl_in.invert;
        r_nxt.pin_oe = ctrl_in.drive;
        // Strobe sequencing, counted in clock output cycles
        case (r_r.st)
            ST_IDLE: begin
                r_nxt.edges = 2'h0;
                if (ctrl_in.strobe_en && portc_wr_in) begin
                    r_nxt.st = ST_WR_WAIT;
                end else if (ctrl_in.strobe_en && portc_rd_in) begin
                    r_nxt.st = ST_RD_ACT;
                end
            end
            ST_WR_WAIT: begin
                if (rise) begin
                    r_nxt.edges = r_r.edges + 2'h1;
                    if (r_r.edges == `STROBE_EDGES - 2'h1) begin
                        r_nxt.edges = 2'h0;
                        r_nxt.st = ST_WR_ACT;
                        r_nxt.wr_n = 1'b0;
                    end
                end
            end
            ST_WR_ACT, ST_RD_ACT: begin
                if (rise && r_r.rd_n && r_r.st == ST_RD_ACT) begin
                    r_nxt.rd_n = 1'b0;                  // on a rise
                end else if (rise) begin
                    r_nxt.edges = r_r.edges + 2'h1;
                    if (r_r.edges == `STROBE_EDGES - 2'h1) begin
                        r_nxt.st = ST_IDLE;
                        r_nxt.rd_n = 1'b1;
                        r_nxt.wr_n = 1'b1;
                    end
                end
            end
            default: begin
                r_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_r <= '{div_cnt: 4'h0, phase: 1'b0, pin: 1'b0,
                     pin_oe: `DRIVE_RESET, st: ST_IDLE, edges: 2'h0,
                     rd_n: 1'b1, wr_n: 1'b1};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign clk_pin_out     = r_r.pin;
    assign clk_pin_oe_out  = r_r.pin_oe;
    assign rd_strobe_n_out = r_r.rd_n;
    assign wr_strobe_n_out = r_r.wr_n;

endmodule : clk_out_strobes

// File: sim/wave_engine_model.sv
// Stand-in for the waveform engine that answers start pulses
`timescale 1ns/1ps

module wave_engine_model #(
    parameter logic [15:0] RD_WORD = 16'habcd
) (
    // Clock
    input  wire         clk_in,
    // Start commands from the bank
    input  wire         go_in,
    input  wire         go_rd_in,
    // Answers to the bank
    output logic        done_out = 1'b0,
    output logic        rvalid_out = 1'b0,
    output logic [15:0] rdata_out = ~RD_WORD
);
    logic [2:0] pend_r = '0;
    logic       rd_r = 1'b0;

    // Done four cycles after a start; data churn while not valid
    always @(posedge clk_in) begin
        pend_r <= {pend_r[1:0], go_in};
        if (go_in)
            rd_r <= go_rd_in;
        done_out <= pend_r[2];
        rvalid_out <= pend_r[2] & rd_r;
        rdata_out <= (pend_r[2] & rd_r) ? RD_WORD : ~rdata_out;
    end
endmodule : wave_engine_model

// File: sim/sfr_bank_checker.sv
// Port assertions for the SFR bank
`timescale 1ns/1ps
`include "cpu_config_map.svh"

module sfr_bank_checker
    import cpu_config_pkg::*;
(
    // Clock, reset and requests
    input wire        clk_in, rst_n_in, host_load_wr_in, host_load_bit_in,
    input wire        portc_rd_in,
    input wire [2:0]  ep_busy_in,
    input sfr_req_t   sfr_req_in,
    input xram_req_t  xram_req_in,
    // Watched outputs
    input logic       fifo_go_out, sgl_go_out, sgl_go_rd_out, core_reset_out,
    input logic       rd_strobe_n_out, wr_strobe_n_out,
    input logic [7:0] sfr_rdata_out, sgl_low_out, port_e_oe_out,
    input logic [2:0] fifo_sel_out,
    input logic [1:0] cpu_speed_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Write strobe held low for its first two cycles
    sequence wr_low_s;
        !wr_strobe_n_out [*2];
    endsequence

    oe_write_a: assert property (sfr_req_in.wr &&
        sfr_req_in.addr == `SFR_PORT_E_OE |=> port_e_oe_out ==
        $past(sfr_req_in.wdata)) else $error("port E enable not stored");
    busy_read_a: assert property (sfr_req_in.rd &&
        sfr_req_in.addr == `SFR_EP01_BUSY && $stable(ep_busy_in) &&
        $past(rst_n_in) |=> sfr_rdata_out == {5'h00, $past(ep_busy_in)})
        else $error("busy read wrong");
    trig_go_a: assert property (sfr_req_in.wr &&
        sfr_req_in.addr == `SFR_XFER_TRIGGER |=> fifo_go_out &&
        fifo_sel_out == $past(sfr_req_in.wdata[2:0])) else $error("no go");
    sgl_start_a: assert property (sfr_req_in.wr &&
        sfr_req_in.addr == `SFR_SGL_LOW_TRIG |=> sgl_go_out && !sgl_go_rd_out
        && sgl_low_out == $past(sfr_req_in.wdata)) else $error("no start");
    speed_set_a: assert property (xram_req_in.wr &&
        xram_req_in.addr == `XR_CPU_CTRL && xram_req_in.wdata[4:3] != 2'h3
        |=> cpu_speed_out == $past(xram_req_in.wdata[4:3]))
        else $error("speed not taken");
    core_hold_a: assert property (host_load_wr_in |=>
        core_reset_out == $past(host_load_bit_in)) else $error("core hold");
    rd_hold_a: assert property ($fell(rd_strobe_n_out) |->
        !rd_strobe_n_out [*2] ##[1:40] rd_strobe_n_out)
        else $error("rd strobe length");
    wr_hold_a: assert property ($fell(wr_strobe_n_out) |->
        wr_low_s ##[1:40] wr_strobe_n_out) else $error("wr strobe length");
endmodule : sfr_bank_checker

bind cpu_config_sfr_bank sfr_bank_checker chk_u (.*);

// File: sim/tb_top.sv
// Self-checking bench for the SFR bank
`timescale 1ns/1ps
`include "cpu_config_map.svh"

module tb_top
    import cpu_config_pkg::*;
;
    logic clk_in = '0, rst_n_in = '0, host_load_wr_in = '0;
    logic host_load_bit_in = '0, bus_16_in = 1'b1, portc_rd_in = '0;
    logic portc_wr_in = '0, xfer_done_in, sgl_rvalid_in, sfr_rvalid_out;
    logic [2:0] ep_busy_in = '0, fifo_sel_out;
    logic [1:0] interface_mode_in = '0, cpu_speed_out;
    sfr_req_t sfr_req_in = '0;
    xram_req_t xram_req_in = '0;
    logic xram_rvalid_out, fifo_go_out, sgl_go_out, sgl_go_rd_out;
    logic core_reset_out, clk_pin_out, clk_pin_oe_out;
    logic rd_strobe_n_out, wr_strobe_n_out;
    logic [15:0] sgl_rdata_in;
    logic [7:0] sfr_rdata_out, xram_rdata_out, sgl_high_out, sgl_low_out;
    logic [7:0] port_e_oe_out, q;
    int bad_count = 0, checked = 0, n;

    always #12.5 clk_in = ~clk_in;

    cpu_config_sfr_bank dut_u (.*);
    wave_engine_model eng_u (.clk_in, .go_in(fifo_go_out | sgl_go_out),
        .go_rd_in(sgl_go_rd_out), .done_out(xfer_done_in),
        .rvalid_out(sgl_rvalid_in), .rdata_out(sgl_rdata_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic step;
        @(posedge clk_in);
        #1;
    endtask : step
    task automatic results;
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    task automatic chk(input string s, input logic [15:0] g, e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // One access on either bus; read data lands in q
    task automatic acc(input bit x, w, input logic [15:0] a,
                       input logic [7:0] d);
        step;
        if (x) xram_req_in = '{a, d, w, !w};
        else sfr_req_in = '{a[7:0], d, w, !w};
        step;
        sfr_req_in = '0;
        xram_req_in = '0;
        if (x) step;
        q = x ? xram_rdata_out : sfr_rdata_out;
    endtask : acc
    task automatic rd(input bit x, input logic [15:0] a, input logic [7:0] e,
                      input string s);
        acc(x, 1'b0, a, '0);
        chk(s, q, e);
    endtask : rd
    task automatic pulse_c(input bit r);
        step;
        if (r) portc_rd_in = 1'b1;
        else portc_wr_in = 1'b1;
        step;
        portc_rd_in = '0;
        portc_wr_in = '0;
    endtask : pulse_c
    // Cycles to next clock pin rise, or a strobe's low time
    task automatic wait_for(input int k, output int c);
        logic o;
        c = 0;
        for (int i = 0; i < 60 && k > 0 && (k == 1 ? wr_strobe_n_out :
             rd_strobe_n_out); i++) step;
        do begin
            o = k == 0 ? clk_pin_out :
                k == 1 ? wr_strobe_n_out : rd_strobe_n_out;
            step;
            c++;
        end while (c < 60 && (k == 0 ? !(clk_pin_out && !o) :
                   !(k == 1 ? wr_strobe_n_out : rd_strobe_n_out)));
        if (c == 60) begin
            bad_count++;
            results;
        end
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(0, `SFR_EP01_BUSY, '0, "busy reset");
        acc(0, 0, `SFR_XFER_TRIGGER, '0);
        chk("trigger reset", q & 8'hf8, 8'h80);
        rd(1, `XR_CPU_CTRL, 8'h02, "control reset");
        chk("port E reset", port_e_oe_out, '0);
    endtask : t_reset
    task automatic t_regs;
        acc(0, 1, `SFR_PORT_E_OE, 8'ha5);
        chk("port E", port_e_oe_out, 8'ha5);
        ep_busy_in = 3'h5;
        acc(0, 1, `SFR_EP01_BUSY, 8'hff);
        rd(0, `SFR_EP01_BUSY, 8'h05, "busy");
        rd(1, `XR_EP0_STAT, 8'h02, "ep0 alias");
        rd(1, `XR_EP1_OUT_STAT, '0, "ep1 out alias");
        rd(1, `XR_EP1_IN_STAT, 8'h02, "ep1 in alias");
        acc(0, 1, `SFR_XFER_TRIGGER, 8'hff);
        chk("fifo go", {fifo_go_out, fifo_sel_out}, 4'hf);
        rd(0, `SFR_XFER_TRIGGER, 8'h07, "done cleared");
        repeat (8) step;
        rd(0, `SFR_XFER_TRIGGER, 8'h87, "done set");
    endtask : t_regs
    task automatic t_single;
        acc(0, 1, `SFR_SGL_HIGH, 8'h12);
        acc(0, 1, `SFR_SGL_LOW_TRIG, 8'h34);
        chk("single go",
            {sgl_go_out, sgl_go_rd_out, sgl_low_out}, 10'h234);
        rd(1, `XR_SGL_HIGH, 8'h12, "high alias");
        rd(1, `XR_SGL_LOW_TRIG, 8'h34, "low alias");
        acc(0, 0, `SFR_SGL_LOW_TRIG, '0);
        chk("single read go", {sgl_go_out, sgl_go_rd_out}, 2'h3);
        repeat (8) step;
        rd(0, `SFR_SGL_HIGH, 8'hab, "engine high");
        rd(0, `SFR_SGL_LOW_QUIET, 8'hcd, "engine low");
        chk("quiet read", sgl_go_out, '0);
    endtask : t_single
    task automatic t_wave;
        acc(1, 1, `XR_WAVE_FIRST, 8'h5a);
        rd(1, `XR_WAVE_FIRST, '0, "window closed");
        interface_mode_in = `MODE_WAVE_MASTER;
        acc(1, 1, `XR_WAVE_LAST, 8'hc3);
        rd(1, `XR_WAVE_LAST, 8'hc3, "window open");
        interface_mode_in = '0;
    endtask : t_wave
    task automatic t_cpu;
        acc(1, 1, `XR_CPU_CTRL, 8'hff);
        rd(1, `XR_CPU_CTRL, 8'h26, "control masked");
        step;
        host_load_wr_in = 1'b1;
        host_load_bit_in = 1'b1;
        step;
        host_load_wr_in = '0;
        chk("core held", core_reset_out, 1'b1);
        acc(1, 1, `XR_CPU_CTRL, 8'h00);
        rd(1, `XR_CPU_CTRL, 8'h01, "core bit firmware");
        chk("pin drive off", clk_pin_oe_out, '0);
        for (int s = 0; s < 3; s++) begin
            acc(1, 1, `XR_CPU_CTRL, {3'h0, s[1:0], 3'h2});
            chk("speed", cpu_speed_out, s[1:0]);
            wait_for(0, n);
            wait_for(0, n);
            chk("clock period", n, 16'h8 >> s);
            chk("pin drive", clk_pin_oe_out, 1'b1);
        end
        acc(1, 1, `XR_CPU_CTRL, 8'h1a);
        chk("reserved speed", cpu_speed_out, `SPEED_48);
    endtask : t_cpu
    task automatic t_strobe;
        acc(1, 1, `XR_CPU_CTRL, 8'h22);
        pulse_c(0);
        wait_for(1, n);
        chk("write strobe", n, 4 * `HALF_12);
        pulse_c(1);
        wait_for(2, n);
        chk("read strobe", n, 4 * `HALF_12);
        acc(1, 1, `XR_CPU_CTRL, 8'h02);
        pulse_c(1);
        repeat (3) step;
        chk("strobe off", rd_strobe_n_out, 1'b1);
    endtask : t_strobe

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        t_reset;
        t_regs;
        t_single;
        t_wave;
        t_cpu;
        t_strobe;
        results;
    end
endmodule : tb_top
